/* File: inc/sgc_pkg.sv */
// Constants for the switch global control block: register map, field
// positions, reset values, scheduler weights and storm period timing.
// Assumes a 25 MHz core clock and an AXI4-Lite register bus.
package sgc_pkg;

  // Clock rate and storm measuring periods.
  localparam int unsigned CLK_HZ        = 25_000_000;
  localparam int unsigned PERIOD_100_MS = 67;
  localparam int unsigned PERIOD_10_MS  = 500;
  localparam int unsigned CYC_100       = CLK_HZ / 1000 * PERIOD_100_MS;
  localparam int unsigned CYC_10        = CLK_HZ / 1000 * PERIOD_10_MS;
  localparam int unsigned PER_W         = 24;

  // Register indices as printed; byte address is four times the index.
  localparam logic [7:0] IDX_VSQ     = 8'h05;
  localparam logic [7:0] IDX_MRS     = 8'h06;
  localparam logic [7:0] IDX_RATE_LO = 8'h07;
  localparam logic [7:0] ADDR_VSQ     = 8'(IDX_VSQ * 8'h04);
  localparam logic [7:0] ADDR_MRS     = 8'(IDX_MRS * 8'h04);
  localparam logic [7:0] ADDR_RATE_LO = 8'(IDX_RATE_LO * 8'h04);

  // Fields of vlan_snoop_queue_control.
  localparam int unsigned BIT_VLAN      = 7;
  localparam int unsigned BIT_IGMP      = 6;
  localparam int unsigned BIT_MLD       = 5;
  localparam int unsigned BIT_MLD_OPT   = 4;
  localparam int unsigned BIT_WFQ       = 3;
  localparam int unsigned BIT_SNIFF_AND = 0;

  // Fields of mii_repeater_storm_control.
  localparam int unsigned BIT_REPEATER  = 7;
  localparam int unsigned BIT_HALF      = 6;
  localparam int unsigned BIT_FLOW      = 5;
  localparam int unsigned BIT_10M       = 4;
  localparam int unsigned BIT_NULL_VID  = 3;
  localparam int unsigned RATE_HI_MSB   = 2;

  // Reset values; strap bits of the second register are ORed in at reset.
  localparam logic [7:0] VSQ_RST     = 8'h00;
  localparam logic [7:0] MRS_RST     = 8'h00;
  localparam logic [7:0] RATE_LO_RST = 8'h63;

  // Scheduler weights for queue_zero up to queue_three.
  localparam int unsigned NQ = 4;
  localparam logic [3:0] WFQ_WEIGHT [NQ] = '{4'h1, 4'h2, 4'h4, 4'h8};

  // Storm limit width, port count and the null VLAN identifier.
  localparam int unsigned LIM_W    = 11;
  localparam int unsigned NPORT    = 3;
  localparam logic [11:0] NULL_VID = 12'h000;

  // AXI responses.
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

/* File: src/sgc_wfq_sched.sv */
// Output queue scheduler: strict priority or weighted fair queueing.
// Assumes queue_busy is on the core clock and tx_slot pulses per free slot.
`timescale 1ns/100ps
module sgc_wfq_sched
  import sgc_pkg::*;
(
  // Clock and reset.
  input  wire logic          aclk,
  input  wire logic          aresetn,
  // Mode and queue state.
  input  wire logic          wfq_enable,
  input  wire logic [NQ-1:0] queue_busy,
  input  wire logic          tx_slot,
  // One-hot grant, one cycle after tx_slot.
  output logic      [NQ-1:0] grant
);

  logic [3:0]    credit      [NQ];
  logic [3:0]    next_credit [NQ];
  logic [3:0]    load        [NQ];
  logic [NQ-1:0] next_grant;
  logic [3:0]    extra;
  logic [1:0]    top;
  logic [1:0]    sel;
  logic          have;

  // Pick the queue to serve and update the per-round credits.
  always_comb
  begin
    next_credit = credit;
    next_grant  = '0;
    load        = credit;
    extra       = '0;
    top         = '0;
    sel         = '0;
    have        = 1'b0;
    if (!wfq_enable)
    begin
      next_credit = '{default: 4'h0};
      for (int q = 0; q < NQ; q++)
        if (queue_busy[q]) sel = 2'(q);
      if (tx_slot && queue_busy != '0) next_grant[sel] = 1'b1;
    end
    else if (tx_slot && queue_busy != '0)
    begin
      for (int q = 0; q < NQ; q++)
        if (queue_busy[q] && credit[q] != '0) have = 1'b1;
      if (!have)
      begin
        for (int q = 0; q < NQ; q++)
        begin
          load[q] = queue_busy[q] ? WFQ_WEIGHT[q] : 4'h0;
          if (!queue_busy[q]) extra = 4'(extra + 4'h1);
          else top = 2'(q);
        end
        load[top] = 4'(load[top] + extra);
      end
      for (int q = 0; q < NQ; q++)
        if (queue_busy[q] && load[q] != '0) sel = 2'(q);
      next_credit      = load;
      next_credit[sel] = 4'(load[sel] - 4'h1);
      next_grant[sel]  = 1'b1;
    end
  end

  // Register credits and grant.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      credit <= '{default: 4'h0};
      grant  <= '0;
    end
    else
    begin
      credit <= next_credit;
      grant  <= next_grant;
    end
  end

endmodule // sgc_wfq_sched

/* File: src/sgc_global_ctrl.sv */
// Global control registers three and four of a three-port switch, with
// the storm rate low byte, behind an AXI4-Lite slave, plus the logic
// these bits steer: snoop forwarding, mirroring, null VID replacement,
// broadcast storm metering and the output queue scheduler.
// Assumes one 25 MHz clock; strap pins are asynchronous and synchronised.
//
// What this block does
// - VLAN enable bit 7 turns on tag-based VLAN mode, resets zero.
// - IGMP snoop bit 6 forwards recognised IGMP packets to the MII port.
// - Bits 5 and 4 enable MLD snooping and its option; reset zero.
// - Fair queue bit clear: strict priority, higher queue always first.
// - Fair queueing with all queues busy shares bandwidth 8:4:2:1.
// - Each empty queue gives one weight unit to highest busy queue.
// - Sniff select set: mirror only when source and destination match.
// - Sniff select clear: mirror when source or destination matches.
// - Repeater bit 7 of the second register, resets zero.
// - Bit 6 selects MII half duplex; reset from the duplex strap.
// - Bit 5 enables MII flow control; reset from the flow strap.
// - Bit 4 selects MII 10Mbps; reset from the speed strap.
// - Straps load their bits at reset; low gives zero, high gives one.
// - Null VID bit 3 replaces a null VLAN identifier with port VID.
// - Bits 2-0 hold bits 10 to 8 of the storm block limit.
// - Storm period is 67ms at 100 Mbit/s, 500ms at 10 Mbit/s.
// - The next register holds limit bits 7-0, reset 0x63.
//
// Register access over AXI4-Lite was decided locally.
`timescale 1ns/100ps
module sgc_global_ctrl
  import sgc_pkg::*;
#(
  parameter int unsigned PERIOD_100_CYC = CYC_100,
  parameter int unsigned PERIOD_10_CYC  = CYC_10
)
(
  // Clock and reset.
  input  wire logic              aclk,
  input  wire logic              aresetn,
  // AXI4-Lite write address and data.
  input  wire logic [7:0]        awaddr,
  input  wire logic              awvalid,
  output logic                   awready,
  input  wire logic [31:0]       wdata,
  input  wire logic [3:0]        wstrb,
  input  wire logic              wvalid,
  output logic                   wready,
  // AXI4-Lite write response.
  output logic [1:0]             bresp,
  output logic                   bvalid,
  input  wire logic              bready,
  // AXI4-Lite read.
  input  wire logic [7:0]        araddr,
  input  wire logic              arvalid,
  output logic                   arready,
  output logic [31:0]            rdata,
  output logic [1:0]             rresp,
  output logic                   rvalid,
  input  wire logic              rready,
  // Strap pins.
  input  wire logic              speed_strap_pin,
  input  wire logic              duplex_strap_pin,
  input  wire logic              flow_control_strap_pin,
  // Configuration levels to the switch core.
  output logic                   vlan_enable,
  output logic                   igmp_snoop_enable,
  output logic                   mld_snoop_enable,
  output logic                   mld_snoop_option,
  output logic                   repeater_enable,
  output logic                   mii_half_duplex,
  output logic                   mii_flow_control,
  output logic                   mii_10m,
  // Packet classification in and decision out.
  input  wire logic              pkt_valid,
  input  wire logic              pkt_is_igmp,
  input  wire logic              pkt_is_mld,
  input  wire logic              pkt_src_sniff,
  input  wire logic              pkt_dst_sniff,
  input  wire logic [11:0]       pkt_vid,
  input  wire logic [11:0]       port_vid,
  output logic                   out_valid,
  output logic                   fwd_to_mii,
  output logic                   mirror,
  output logic [11:0]            out_vid,
  // Broadcast storm metering per input port.
  input  wire logic [NPORT-1:0]  port_10m,
  input  wire logic [NPORT-1:0]  bcast_block,
  output logic      [NPORT-1:0]  storm_drop,
  // Output scheduler.
  input  wire logic [NQ-1:0]     queue_busy,
  input  wire logic              tx_slot,
  output logic      [NQ-1:0]     tx_grant
);

  localparam logic [PER_W-1:0] P100 = PER_W'(PERIOD_100_CYC - 1);
  localparam logic [PER_W-1:0] P10  = PER_W'(PERIOD_10_CYC - 1);

  logic [2:0]  strap_meta;
  logic [2:0]  strap_sync;
  logic [7:0]  vsq;
  logic [7:0]  mrs;
  logic [7:0]  rate_lo;
  logic [7:0]  next_vsq;
  logic [7:0]  next_mrs;
  logic [7:0]  next_rate_lo;
  logic [7:0]  strap_val;
  logic        aw_got;
  logic        w_got;
  logic [7:0]  wr_addr;
  logic [7:0]  wr_data;
  logic        wr_lane;
  logic        next_aw_got;
  logic        next_w_got;
  logic [7:0]  next_wr_addr;
  logic [7:0]  next_wr_data;
  logic        next_wr_lane;
  logic        next_bvalid;
  logic [1:0]  next_bresp;
  logic        next_rvalid;
  logic [1:0]  next_rresp;
  logic [31:0] next_rdata;
  logic        do_write;
  logic        wr_hit;
  logic [LIM_W-1:0] limit;

  // Strap pins cross into the clock domain through two flip-flops.
  always_ff @(posedge aclk)
  begin
    strap_meta <= {flow_control_strap_pin, duplex_strap_pin, speed_strap_pin};
    strap_sync <= strap_meta;
  end

  // Reset image of the MII register with the strap levels in place.
  always_comb
  begin
    strap_val               = MRS_RST;
    strap_val[BIT_10M]      = strap_sync[0];
    strap_val[BIT_HALF]     = strap_sync[1];
    strap_val[BIT_FLOW]     = strap_sync[2];
  end

  // Write channel: address and data taken in either order.
  always_comb
  begin
    next_aw_got  = aw_got;
    next_w_got   = w_got;
    next_wr_addr = wr_addr;
    next_wr_data = wr_data;
    next_wr_lane = wr_lane;
    next_bvalid  = bvalid;
    next_bresp   = bresp;
    do_write     = 1'b0;
    if (awvalid && awready)
    begin
      next_aw_got  = 1'b1;
      next_wr_addr = awaddr;
    end
    if (wvalid && wready)
    begin
      next_w_got   = 1'b1;
      next_wr_data = wdata[7:0];
      next_wr_lane = wstrb[0];
    end
    if (aw_got && w_got && !bvalid)
    begin
      do_write    = 1'b1;
      next_bvalid = 1'b1;
      next_bresp  = wr_hit ? RESP_OKAY : RESP_SLVERR;
    end
    if (bvalid && bready)
    begin
      next_bvalid = 1'b0;
      next_aw_got = 1'b0;
      next_w_got  = 1'b0;
    end
  end

  assign wr_hit = (wr_addr == ADDR_VSQ) || (wr_addr == ADDR_MRS)
                  || (wr_addr == ADDR_RATE_LO);

  // Register file next values; a write steers the low byte lane only.
  always_comb
  begin
    next_vsq     = vsq;
    next_mrs     = mrs;
    next_rate_lo = rate_lo;
    if (do_write && wr_lane)
    begin
      if (wr_addr == ADDR_VSQ)
        next_vsq = wr_data;
      if (wr_addr == ADDR_MRS)
        next_mrs = wr_data;
      if (wr_addr == ADDR_RATE_LO)
        next_rate_lo = wr_data;
    end
  end

  // Read channel: one answer the cycle after the address is taken.
  always_comb
  begin
    next_rvalid = rvalid;
    next_rresp  = rresp;
    next_rdata  = rdata;
    if (arvalid && arready)
    begin
      next_rvalid = 1'b1;
      next_rresp  = RESP_OKAY;
      next_rdata  = '0;
      unique case (araddr)
        ADDR_VSQ:     next_rdata[7:0] = vsq;
        ADDR_MRS:     next_rdata[7:0] = mrs;
        ADDR_RATE_LO: next_rdata[7:0] = rate_lo;
        default:      next_rresp = RESP_SLVERR;
      endcase
    end
    else if (rvalid && rready)
      next_rvalid = 1'b0;
  end

  // Bus and register state; straps load the MII bits during reset.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      vsq     <= VSQ_RST;
      mrs     <= strap_val;
      rate_lo <= RATE_LO_RST;
      aw_got  <= 1'b0;
      w_got   <= 1'b0;
      wr_addr <= '0;
      wr_data <= '0;
      wr_lane <= 1'b0;
      awready <= 1'b0;
      wready  <= 1'b0;
      bvalid  <= 1'b0;
      bresp   <= RESP_OKAY;
      arready <= 1'b0;
      rvalid  <= 1'b0;
      rresp   <= RESP_OKAY;
      rdata   <= '0;
    end
    else
    begin
      vsq     <= next_vsq;
      mrs     <= next_mrs;
      rate_lo <= next_rate_lo;
      aw_got  <= next_aw_got;
      w_got   <= next_w_got;
      wr_addr <= next_wr_addr;
      wr_data <= next_wr_data;
      wr_lane <= next_wr_lane;
      awready <= !next_aw_got;
      wready  <= !next_w_got;
      bvalid  <= next_bvalid;
      bresp   <= next_bresp;
      arready <= !next_rvalid;
      rvalid  <= next_rvalid;
      rresp   <= next_rresp;
      rdata   <= next_rdata;
    end
  end

  // Configuration levels come straight from the register flip-flops.
  assign vlan_enable       = vsq[BIT_VLAN];
  assign igmp_snoop_enable = vsq[BIT_IGMP];
  assign mld_snoop_enable  = vsq[BIT_MLD];
  assign mld_snoop_option  = vsq[BIT_MLD_OPT];
  assign repeater_enable   = mrs[BIT_REPEATER];
  assign mii_half_duplex   = mrs[BIT_HALF];
  assign mii_flow_control  = mrs[BIT_FLOW];
  assign mii_10m           = mrs[BIT_10M];
  assign limit             = {mrs[RATE_HI_MSB:0], rate_lo};

  // Per-packet decisions, registered one cycle behind the classification.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      out_valid  <= 1'b0;
      fwd_to_mii <= 1'b0;
      mirror     <= 1'b0;
      out_vid    <= '0;
    end
    else
    begin
      out_valid  <= pkt_valid;
      fwd_to_mii <= pkt_valid && ((vsq[BIT_IGMP] && pkt_is_igmp)
                    || (vsq[BIT_MLD] && pkt_is_mld));
      mirror     <= pkt_valid && (vsq[BIT_SNIFF_AND]
                    ? (pkt_src_sniff && pkt_dst_sniff)
                    : (pkt_src_sniff || pkt_dst_sniff));
      out_vid    <= (mrs[BIT_NULL_VID] && pkt_vid == NULL_VID)
                    ? port_vid : pkt_vid;
    end
  end

  // Storm metering: one period timer and one block counter per port.
  generate
    for (genvar p = 0; p < NPORT; p++)
    begin : g_storm
      logic [PER_W-1:0] per;
      logic [PER_W-1:0] next_per;
      logic [LIM_W-1:0] blocks;
      logic [LIM_W-1:0] next_blocks;
      logic             next_drop;

      // Count blocks up to the limit and restart on each period end.
      always_comb
      begin
        next_per    = PER_W'(per + 1'b1);
        next_blocks = blocks;
        if (per >= (port_10m[p] ? P10 : P100))
        begin
          next_per    = '0;
          next_blocks = '0;
        end
        // A block on the restart edge counts as the first of the new period.
        if (bcast_block[p] && next_blocks < limit)
          next_blocks = LIM_W'(next_blocks + 1'b1);
        next_drop = (next_blocks >= limit);
      end

      // Register the timer, the count and the drop flag.
      always_ff @(posedge aclk)
      begin
        if (!aresetn)
        begin
          per           <= '0;
          blocks        <= '0;
          storm_drop[p] <= 1'b0;
        end
        else
        begin
          per           <= next_per;
          blocks        <= next_blocks;
          storm_drop[p] <= next_drop;
        end
      end
    end
  endgenerate

  // Output queue scheduler steered by the fair queue bit.
  sgc_wfq_sched u_sched
  (
    .aclk       (aclk),
    .aresetn    (aresetn),
    .wfq_enable (vsq[BIT_WFQ]),
    .queue_busy (queue_busy),
    .tx_slot    (tx_slot),
    .grant      (tx_grant)
  );

endmodule // sgc_global_ctrl

/* File: bench/sgc_global_ctrl_monitor.sv */
// Checker for the global control block: bus answers, packet decisions,
// scheduler grants and storm drops. Sees only the top module's ports.
`timescale 1ns/100ps
module sgc_global_ctrl_monitor
  import sgc_pkg::*;
(
  // Clock, reset and register bus handshakes.
  input wire logic             aclk, aresetn, awvalid, awready, wvalid, wready,
  input wire logic             bvalid, bready, arvalid, arready, rvalid, rready,
  input wire logic [31:0]      rdata,
  // Straps and configuration levels.
  input wire logic             speed_strap_pin, duplex_strap_pin, flow_control_strap_pin,
  input wire logic             vlan_enable, igmp_snoop_enable, mld_snoop_enable,
  input wire logic             mld_snoop_option, repeater_enable, mii_half_duplex,
  input wire logic             mii_flow_control, mii_10m,
  // Packet path, storm metering and scheduler.
  input wire logic             pkt_valid, pkt_is_igmp, pkt_is_mld, pkt_src_sniff,
  input wire logic             pkt_dst_sniff, out_valid, fwd_to_mii, mirror, tx_slot,
  input wire logic [NPORT-1:0] bcast_block, storm_drop,
  input wire logic [NQ-1:0]    queue_busy, tx_grant
);
  // All checks run on the core clock and rest while reset is low.
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  rst_straps_a: assert property ($rose(aresetn) |-> mii_10m == speed_strap_pin
    && mii_half_duplex == duplex_strap_pin && mii_flow_control == flow_control_strap_pin
    && !vlan_enable && !mld_snoop_enable && !mld_snoop_option && !repeater_enable)
    else $error("Reset levels do not follow the straps");
  igmp_fwd_a: assert property (pkt_valid && pkt_is_igmp && igmp_snoop_enable
    |=> out_valid && fwd_to_mii) else $error("Snooped IGMP packet not forwarded");
  mld_fwd_a: assert property (pkt_valid && pkt_is_mld && mld_snoop_enable
    |=> out_valid && fwd_to_mii) else $error("Snooped MLD packet not forwarded");
  snoop_off_a: assert property (!(pkt_valid && pkt_is_igmp && igmp_snoop_enable)
    && !(pkt_valid && pkt_is_mld && mld_snoop_enable) |=> !fwd_to_mii)
    else $error("Packet forwarded without snooping");
  mirror_both_a: assert property (pkt_valid && pkt_src_sniff && pkt_dst_sniff
    |=> mirror) else $error("Packet matching both ports not mirrored");
  mirror_none_a: assert property (pkt_valid && !pkt_src_sniff && !pkt_dst_sniff
    |=> !mirror) else $error("Packet matching no port mirrored");
  grant_busy_a: assert property (tx_slot |=> $onehot0(tx_grant)
    && (tx_grant & ~$past(queue_busy)) == '0 && ((tx_grant != '0) == ($past(queue_busy) != '0)))
    else $error("Grant not one busy queue");
  grant_idle_a: assert property (!tx_slot |=> tx_grant == '0)
    else $error("Grant without a transmit slot");
  write_resp_a: assert property (awvalid && awready && wvalid && wready |-> ##2 bvalid)
    else $error("Write response late");
  read_answer_a: assert property (arvalid && arready |=> rvalid && !arready
    && rdata[31:8] == '0) else $error("Read answer not as expected");
  storm_cause_a: assert property ($rose(storm_drop[0]) |-> $past(bcast_block[0]))
    else $error("Storm drop without a block");
endmodule // sgc_global_ctrl_monitor

bind sgc_global_ctrl sgc_global_ctrl_monitor u_mon (.*);

/* File: bench/sgc_global_ctrl_tb.sv */
// Testbench for the switch global control block: register rows, then
// packet decisions, storm metering, scheduler and a strapped reset.
// Assumes the AXI4-Lite slave answers as the block's hand-over says.
`timescale 1ns/100ps
module sgc_global_ctrl_tb;
  import sgc_pkg::*;
  // Design ports under their own names.
  logic aclk = 1'b0, aresetn = 1'b0, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic arvalid = 1'b0, rready = 1'b0, awready, wready, bvalid, arready, rvalid;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata, rd, cnt;
  logic [3:0] wstrb = 4'h0;
  logic [1:0] bresp, rresp, resp;
  logic speed_strap_pin = 1'b0, duplex_strap_pin = 1'b0, flow_control_strap_pin = 1'b0;
  logic vlan_enable, igmp_snoop_enable, mld_snoop_enable, mld_snoop_option;
  logic repeater_enable, mii_half_duplex, mii_flow_control, mii_10m;
  logic pkt_valid = 1'b0, pkt_is_igmp = 1'b0, pkt_is_mld = 1'b0, tx_slot = 1'b0;
  logic pkt_src_sniff = 1'b0, pkt_dst_sniff = 1'b0, out_valid, fwd_to_mii, mirror;
  logic [11:0] pkt_vid = 12'h000, port_vid = 12'h3a5, out_vid;
  logic [NPORT-1:0] port_10m = '0, bcast_block = '0, storm_drop;
  logic [NQ-1:0] queue_busy = '0, tx_grant;
  logic [7:0] cfg;
  int err_count = 0, total_checks = 0, cycles = 0;
  // Register rows: address, write, read back, response, config levels.
  // Rows keep reserved bits at zero, pair repeater mode with half duplex on
  // 100 Mbit ports, and take the VLAN table as filled before VLAN mode.
  typedef struct packed {logic [7:0] a, w, r; logic [1:0] s; logic [7:0] c;} sgc_row_t;
  localparam sgc_row_t ROWS [6] = '{'{ADDR_VSQ, 8'hf9, 8'hf9, RESP_OKAY, 8'hf0},
    '{ADDR_MRS, 8'he9, 8'he9, RESP_OKAY, 8'hfe}, '{ADDR_RATE_LO, 8'h5a, 8'h5a, RESP_OKAY, 8'hfe},
    '{8'h20, 8'hff, 8'h00, RESP_SLVERR, 8'hfe}, '{ADDR_VSQ, 8'h08, 8'h08, RESP_OKAY, 8'h0e},
    '{ADDR_MRS, 8'h58, 8'h58, RESP_OKAY, 8'h05}};

  // Design under test with short storm periods.
  sgc_global_ctrl #(.PERIOD_100_CYC(20), .PERIOD_10_CYC(50)) DUT (.*);
  assign cfg = {vlan_enable, igmp_snoop_enable, mld_snoop_enable, mld_snoop_option,
                repeater_enable, mii_half_duplex, mii_flow_control, mii_10m};

  // Clock and hang limit.
  always #20 aclk = ~aclk;
  always @(posedge aclk)
  begin
    cycles <= cycles + 1;
    if (cycles == 20000)
    begin
      err_count++;
      conclude();
    end
  end

  task automatic conclude;
    $display("checks %0d errors %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    total_checks++;
    if (got !== exp)
    begin
      err_count++;
      $display("MISMATCH at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  // Reset with the given straps {duplex, flow, speed}, held six cycles.
  task automatic do_reset(input logic [2:0] s);
    @(posedge aclk);
    aresetn <= 1'b0;
    {duplex_strap_pin, flow_control_strap_pin, speed_strap_pin} <= s;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
  endtask

  // Write address and data offered together; each dropped once taken.
  task automatic axi_write(input logic [7:0] a, input logic [7:0] d, output logic [1:0] r);
    @(posedge aclk);
    awaddr <= a; wdata <= {24'h0, d}; wstrb <= 4'h1;
    awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
    // No limit of its own; the hang counter ends a lost answer.
    forever
    begin
      @(posedge aclk);
      if (awready === 1'b1) awvalid <= 1'b0;
      if (wready === 1'b1) wvalid <= 1'b0;
      if (bvalid === 1'b1) break;
    end
    r = bresp;
    bready <= 1'b0;
  endtask

  task automatic axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
    forever
    begin
      @(posedge aclk);
      if (arready === 1'b1) arvalid <= 1'b0;
      if (rvalid === 1'b1) break;
    end
    d = rdata; r = rresp;
    rready <= 1'b0;
  endtask

  // One packet {igmp, mld, src, dst}; expects {fwd, mirror, vid} next cycle.
  task automatic pkt(input logic [3:0] k, input logic [11:0] v, input logic [13:0] e);
    @(posedge aclk);
    {pkt_is_igmp, pkt_is_mld, pkt_src_sniff, pkt_dst_sniff} <= k;
    pkt_vid <= v; pkt_valid <= 1'b1;
    @(posedge aclk);
    pkt_valid <= 1'b0;
    @(posedge aclk);
    check({17'h0, out_valid, fwd_to_mii, mirror, out_vid}, {17'h0, 1'b1, e}, "packet");
  endtask

  // Offer n transmit slots with queues b busy; count grants per queue.
  task automatic sched(input logic [3:0] b, input int n, input logic [31:0] e);
    cnt = '0;
    repeat (n)
    begin
      @(posedge aclk);
      queue_busy <= b; tx_slot <= 1'b1;
      @(posedge aclk);
      tx_slot <= 1'b0;
      @(posedge aclk);
      for (int q = 0; q < 4; q++) if (tx_grant[q] === 1'b1) cnt[8*q +: 8] += 8'h01;
    end
    check(cnt, e, "grant counts");
  endtask

  // Main sequence.
  initial
  begin
    do_reset(3'b000);
    foreach (ROWS[i])
    begin
      axi_write(ROWS[i].a, ROWS[i].w, resp);
      check({30'h0, resp}, {30'h0, ROWS[i].s}, "write response");
      axi_read(ROWS[i].a, rd, resp);
      check(rd, {24'h0, ROWS[i].r}, "read data");
      check({30'h0, resp}, {30'h0, ROWS[i].s}, "read response");
      check({24'h0, cfg}, {24'h0, ROWS[i].c}, "config levels");
    end
    pkt(4'b1010, 12'h000, {2'b01, 12'h3a5});
    pkt(4'b0100, 12'h007, {2'b00, 12'h007});
    axi_write(ADDR_VSQ, 8'hf9, resp);
    pkt(4'b1010, 12'h000, {2'b10, 12'h3a5});
    pkt(4'b0111, 12'h123, {2'b11, 12'h123});
    axi_write(ADDR_MRS, 8'h50, resp);
    pkt(4'b0001, 12'h000, {2'b00, 12'h000});
    axi_write(ADDR_RATE_LO, 8'h02, resp);
    @(posedge aclk);
    port_10m <= 3'b001; bcast_block <= 3'b011;
    @(posedge aclk);
    bcast_block <= 3'b001;
    @(posedge aclk);
    bcast_block <= 3'b000;
    @(posedge aclk);
    check({29'h0, storm_drop}, 32'h1, "storm drop at limit");
    repeat (30) @(posedge aclk);
    check({29'h0, storm_drop}, 32'h1, "storm count held past short period");
    repeat (30) @(posedge aclk);
    check({29'h0, storm_drop}, 32'h0, "storm count restarted");
    axi_write(ADDR_VSQ, 8'h08, resp);
    sched(4'hf, 15, 32'h08040201);
    sched(4'hb, 12, 32'h09000201);
    axi_write(ADDR_VSQ, 8'h00, resp);
    sched(4'h7, 4, 32'h00040000);
    do_reset(3'b101);
    axi_read(ADDR_MRS, rd, resp);
    check(rd, 32'h50, "strapped reset value");
    axi_read(ADDR_VSQ, rd, resp);
    check(rd, 32'h00, "first register reset");
    axi_read(ADDR_RATE_LO, rd, resp);
    check(rd, 32'h63, "rate low reset");
    check({24'h0, cfg}, 32'h05, "strapped levels");
    conclude();
  end
endmodule // sgc_global_ctrl_tb
